/* rtl/usc_pkg.sv */
// Package of constants and types for the serial core
// Assumes a single APB clock domain and word-aligned register access
package usc_pkg;
   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] USC_DATA_OFS    = 8'h00;
   localparam logic [7:0] USC_MODE_OFS    = 8'h04;
   localparam logic [7:0] USC_PER_OFS     = 8'h08;
   localparam logic [7:0] USC_FRAC_OFS    = 8'h0C;
   localparam logic [7:0] USC_CFG_OFS     = 8'h10;
   localparam logic [7:0] USC_STAT_OFS    = 8'h14;
   // ---------------------------------------------------------------
   // Field positions and values
   // ---------------------------------------------------------------
   localparam int         USC_CFG_RTS     = 0;
   localparam int         USC_CFG_FLOW    = 1;
   localparam int         USC_CFG_8BIT    = 2;
   localparam int         USC_CFG_2STP    = 3;
   localparam int         USC_CFG_PAR     = 4;
   localparam int         USC_CFG_ODD     = 5;
   localparam int         USC_CFG_AUTO    = 6;
   localparam logic [2:0] USC_MODE_ASYNC  = 3'h1;
   localparam logic [2:0] USC_MODE_RST    = 3'h0;
   localparam logic [15:0] USC_PER_RST    = 16'h0008;
   localparam logic [6:0] USC_CFG_RST     = 7'h00;
   localparam logic [2:0] USC_FIFO_DEPTH  = 3'h4;
   localparam logic [2:0] USC_RTS_LIMIT   = 3'h2;
   // ---------------------------------------------------------------
   // State types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      USC_IDLE, USC_START, USC_DATA, USC_PAR, USC_STOP
   } usc_state_type;
endpackage

/* rtl/usc_core.sv */
// Asynchronous serial transmitter and receiver with APB registers
// Assumes APB master on REF_CLK_IN and line inputs synchronous to it
// Notes on behaviour
// - Function select value 1 enables operation
// - Only first instance holds the function
// - Bit time is 2N plus F cycles
// - Width bit picks 7 or 8 data
// - Stop bit picks one or two stops
// - Receiver needs only one stop bit
// - Parity enable adds parity both directions
// - Even is XOR of data, odd inverts
// - Start, LSB first data, parity, stops
// - Frame spans 9 to 12 bit times
// - Line idles high, low level seen in idle starts receive
// - Separate four-entry transmit and receive FIFOs
// - Data write pushes transmit FIFO
// - Data read pops oldest receive entry
// - DMA channels share both FIFOs
// - Handshake drives ready out, samples permit
// - Handshake pins used only when enabled
// - Permit gates new character, not current one
// - Auto ready low while room for two
// - Otherwise ready follows software level
module usc_core
   import usc_pkg::*;
#(
   parameter bit HAS_ASYNC = 1'b1
) (
   // Clock and reset
   input  wire logic        REF_CLK_IN,
   input  wire logic        NRST_IN,
   // APB slave
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [7:0]  PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   output logic      [31:0] PRDATA_OUT,
   output logic             PREADY_OUT,
   output logic             PSLVERR_OUT,
   // DMA channels
   input  wire logic        TX_DMA_REQ_IN,
   input  wire logic [7:0]  TX_DMA_DATA_IN,
   output logic             TX_DMA_ACK_OUT,
   input  wire logic        RX_DMA_REQ_IN,
   output logic             RX_DMA_ACK_OUT,
   output logic      [7:0]  RX_DMA_DATA_OUT,
   // Serial line
   output logic             TXD_OUT,
   input  wire logic        RXD_IN,
   input  wire logic        TX_PERMIT_N_IN,
   output logic             RX_READY_REQUEST_N_OUT
);
   // ---------------------------------------------------------------
   // Registers and bus decode
   // ---------------------------------------------------------------
   logic [2:0]  function_select_q;
   logic [15:0] baud_integer_divisor_q;
   logic        baud_fraction_bit_q;
   logic [6:0]  async_config_word_q;
   logic        pready_q;
   logic [31:0] prdata_q;
   logic        pslverr_q;
   logic        enabled;
   logic        hs_en;
   logic [16:0] period;
   logic        apb_done;
   logic        data_wr;
   logic        data_rd;
   logic        mapped;
   logic [7:0]  tx_mem [0:3];
   logic [1:0]  tx_wp_q;
   logic [1:0]  tx_rp_q;
   logic [2:0]  tx_cnt_q;
   logic [9:0]  rx_mem [0:3];
   logic [1:0]  rx_wp_q;
   logic [1:0]  rx_rp_q;
   logic [2:0]  rx_cnt_q;
   logic        rx_ovf_q;
   logic        tx_push;
   logic        tx_pop;
   logic        rx_push;
   logic        rx_pop;
   logic        dma_tx_go;
   logic        dma_rx_go;
   logic [9:0]  rx_word;
   usc_state_type tx_st_q;

   assign enabled = HAS_ASYNC && function_select_q == USC_MODE_ASYNC;
   assign hs_en   = enabled && async_config_word_q[USC_CFG_FLOW];
   assign period  = {baud_integer_divisor_q, 1'b0}
                  + {16'h0000, baud_fraction_bit_q};
   assign apb_done = PSEL_IN && PENABLE_IN && pready_q;
   assign mapped   = PADDR_IN <= USC_STAT_OFS && PADDR_IN[1:0] == 2'b00;
   assign data_wr  = apb_done && PWRITE_IN && PADDR_IN == USC_DATA_OFS;
   assign data_rd  = apb_done && !PWRITE_IN && PADDR_IN == USC_DATA_OFS;

   always_ff @(posedge REF_CLK_IN) begin
      if (!NRST_IN) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= PSEL_IN && !PENABLE_IN;
         pslverr_q <= PSEL_IN && !PENABLE_IN && !mapped;
         if (PSEL_IN && !PENABLE_IN) begin
            if (PADDR_IN == USC_DATA_OFS) begin
               prdata_q <= {24'h00_0000, rx_mem[rx_rp_q][7:0]};
            end else if (PADDR_IN == USC_MODE_OFS) begin
               prdata_q <= {29'h0000_0000, function_select_q};
            end else if (PADDR_IN == USC_PER_OFS) begin
               prdata_q <= {16'h0000, baud_integer_divisor_q};
            end else if (PADDR_IN == USC_FRAC_OFS) begin
               prdata_q <= {31'h0000_0000, baud_fraction_bit_q};
            end else if (PADDR_IN == USC_CFG_OFS) begin
               prdata_q <= {25'h000_0000, async_config_word_q};
            end else if (PADDR_IN == USC_STAT_OFS) begin
               prdata_q <= {25'h000_0000,
                  tx_cnt_q == 3'h0 && tx_st_q == USC_IDLE,
                  rx_cnt_q != 3'h0 && rx_mem[rx_rp_q][9],
                  rx_cnt_q != 3'h0 && rx_mem[rx_rp_q][8],
                  rx_ovf_q, tx_cnt_q != USC_FIFO_DEPTH,
                  rx_cnt_q != 3'h0, TX_PERMIT_N_IN};
            end else begin
               prdata_q <= 32'h0000_0000;
            end
         end
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (!NRST_IN) begin
         function_select_q     <= USC_MODE_RST;
         baud_integer_divisor_q <= USC_PER_RST;
         baud_fraction_bit_q   <= 1'b0;
         async_config_word_q   <= USC_CFG_RST;
      end else if (apb_done && PWRITE_IN) begin
         if (PADDR_IN == USC_MODE_OFS) begin
            function_select_q <= PWDATA_IN[2:0];
         end else if (PADDR_IN == USC_PER_OFS) begin
            baud_integer_divisor_q <= PWDATA_IN[15:0];
         end else if (PADDR_IN == USC_FRAC_OFS) begin
            baud_fraction_bit_q <= PWDATA_IN[0];
         end else if (PADDR_IN == USC_CFG_OFS) begin
            async_config_word_q <= PWDATA_IN[6:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // FIFOs shared by software and DMA
   // ---------------------------------------------------------------
   logic tx_pop_req;
   assign dma_tx_go = TX_DMA_REQ_IN && !data_wr && !TX_DMA_ACK_OUT
                    && tx_cnt_q != USC_FIFO_DEPTH;
   assign tx_push   = (data_wr && tx_cnt_q != USC_FIFO_DEPTH)
                    || dma_tx_go;
   assign tx_pop    = tx_pop_req;
   assign dma_rx_go = RX_DMA_REQ_IN && !data_rd && !RX_DMA_ACK_OUT
                    && rx_cnt_q != 3'h0;
   assign rx_pop    = (data_rd && rx_cnt_q != 3'h0) || dma_rx_go;

   always_ff @(posedge REF_CLK_IN) begin
      if (!NRST_IN) begin
         tx_wp_q        <= 2'h0;
         tx_rp_q        <= 2'h0;
         tx_cnt_q       <= 3'h0;
         TX_DMA_ACK_OUT <= 1'b0;
      end else begin
         TX_DMA_ACK_OUT <= dma_tx_go;
         if (tx_push) begin
            tx_mem[tx_wp_q] <= dma_tx_go ? TX_DMA_DATA_IN : PWDATA_IN[7:0];
            tx_wp_q         <= tx_wp_q + 2'h1;
         end
         if (tx_pop) begin
            tx_rp_q <= tx_rp_q + 2'h1;
         end
         tx_cnt_q <= tx_cnt_q + {2'h0, tx_push} - {2'h0, tx_pop};
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (!NRST_IN) begin
         rx_wp_q         <= 2'h0;
         rx_rp_q         <= 2'h0;
         rx_cnt_q        <= 3'h0;
         rx_ovf_q        <= 1'b0;
         RX_DMA_ACK_OUT  <= 1'b0;
         RX_DMA_DATA_OUT <= 8'h00;
      end else begin
         RX_DMA_ACK_OUT <= dma_rx_go;
         if (dma_rx_go) begin
            RX_DMA_DATA_OUT <= rx_mem[rx_rp_q][7:0];
         end
         if (rx_push && rx_cnt_q != USC_FIFO_DEPTH) begin
            rx_mem[rx_wp_q] <= rx_word;
            rx_wp_q         <= rx_wp_q + 2'h1;
         end
         if (rx_pop) begin
            rx_rp_q <= rx_rp_q + 2'h1;
         end
         rx_cnt_q <= rx_cnt_q
                   + {2'h0, rx_push && rx_cnt_q != USC_FIFO_DEPTH}
                   - {2'h0, rx_pop};
         if (rx_push && rx_cnt_q == USC_FIFO_DEPTH) begin
            rx_ovf_q <= 1'b1;
         end else if (data_rd) begin
            rx_ovf_q <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Transmitter
   // ---------------------------------------------------------------
   logic [16:0]   tx_tmr_q;
   logic [2:0]    tx_bit_q;
   logic [7:0]    tx_sh_q;
   logic          tx_par_q;
   logic          tx_stop2_q;
   logic          tx_may_go;
   logic [7:0]    tx_head;
   logic [2:0]    last_bit;

   assign last_bit  = async_config_word_q[USC_CFG_8BIT] ? 3'h7 : 3'h6;
   assign tx_head   = async_config_word_q[USC_CFG_8BIT] ? tx_mem[tx_rp_q]
                    : {1'b0, tx_mem[tx_rp_q][6:0]};
   assign tx_may_go = enabled && tx_cnt_q != 3'h0
                    && (!hs_en || !TX_PERMIT_N_IN);
   assign tx_pop_req = tx_st_q == USC_IDLE && tx_may_go;

   always_ff @(posedge REF_CLK_IN) begin
      if (!NRST_IN) begin
         tx_st_q    <= USC_IDLE;
         tx_tmr_q   <= 17'h0_0000;
         tx_bit_q   <= 3'h0;
         tx_sh_q    <= 8'h00;
         tx_par_q   <= 1'b0;
         tx_stop2_q <= 1'b0;
         TXD_OUT    <= 1'b1;
      end else if (tx_st_q == USC_IDLE) begin
         TXD_OUT <= 1'b1;
         if (tx_may_go) begin
            tx_sh_q    <= tx_head;
            tx_par_q   <= ^tx_head
                        ^ async_config_word_q[USC_CFG_ODD];
            tx_stop2_q <= async_config_word_q[USC_CFG_2STP];
            tx_tmr_q   <= period - 17'h0_0001;
            TXD_OUT    <= 1'b0;
            tx_st_q    <= USC_START;
         end
      end else if (tx_tmr_q != 17'h0_0000) begin
         tx_tmr_q <= tx_tmr_q - 17'h0_0001;
      end else begin
         tx_tmr_q <= period - 17'h0_0001;
         case (tx_st_q)
            USC_START: begin
               TXD_OUT  <= tx_sh_q[0];
               tx_sh_q  <= tx_sh_q >> 1;
               tx_bit_q <= 3'h0;
               tx_st_q  <= USC_DATA;
            end
            USC_DATA: begin
               if (tx_bit_q != last_bit) begin
                  TXD_OUT  <= tx_sh_q[0];
                  tx_sh_q  <= tx_sh_q >> 1;
                  tx_bit_q <= tx_bit_q + 3'h1;
               end else if (async_config_word_q[USC_CFG_PAR]) begin
                  TXD_OUT <= tx_par_q;
                  tx_st_q <= USC_PAR;
               end else begin
                  TXD_OUT <= 1'b1;
                  tx_st_q <= USC_STOP;
               end
            end
            USC_PAR: begin
               TXD_OUT <= 1'b1;
               tx_st_q <= USC_STOP;
            end
            USC_STOP: begin
               if (tx_stop2_q) begin
                  tx_stop2_q <= 1'b0;
               end else begin
                  tx_st_q <= USC_IDLE;
               end
            end
            default: begin
               tx_st_q <= USC_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Receiver
   // ---------------------------------------------------------------
   usc_state_type rx_st_q;
   logic [16:0]   rx_tmr_q;
   logic [2:0]    rx_bit_q;
   logic [7:0]    rx_sh_q;
   logic          rx_perr_q;
   logic          rx_done_q;
   logic          rx_ferr_q;

   assign rx_push = rx_done_q;
   assign rx_word = {rx_perr_q, rx_ferr_q, rx_sh_q};

   always_ff @(posedge REF_CLK_IN) begin
      if (!NRST_IN) begin
         rx_st_q   <= USC_IDLE;
         rx_tmr_q  <= 17'h0_0000;
         rx_bit_q  <= 3'h0;
         rx_sh_q   <= 8'h00;
         rx_perr_q <= 1'b0;
         rx_ferr_q <= 1'b0;
         rx_done_q <= 1'b0;
      end else begin
         rx_done_q <= 1'b0;
         if (!enabled) begin
            rx_st_q <= USC_IDLE;
         end else if (rx_st_q == USC_IDLE) begin
            if (!RXD_IN) begin
               rx_tmr_q <= {1'b0, baud_integer_divisor_q}
                         - 17'h0_0001;
               rx_st_q  <= USC_START;
            end
         end else if (rx_tmr_q != 17'h0_0000) begin
            rx_tmr_q <= rx_tmr_q - 17'h0_0001;
         end else begin
            rx_tmr_q <= period - 17'h0_0001;
            case (rx_st_q)
               USC_START: begin
                  rx_bit_q  <= 3'h0;
                  rx_sh_q   <= 8'h00;
                  rx_perr_q <= 1'b0;
                  rx_st_q   <= RXD_IN ? USC_IDLE : USC_DATA;
               end
               USC_DATA: begin
                  rx_sh_q[rx_bit_q] <= RXD_IN;
                  rx_bit_q          <= rx_bit_q + 3'h1;
                  if (rx_bit_q == last_bit) begin
                     rx_st_q <= async_config_word_q[USC_CFG_PAR]
                              ? USC_PAR : USC_STOP;
                  end
               end
               USC_PAR: begin
                  rx_perr_q <= RXD_IN ^ (^rx_sh_q)
                             ^ async_config_word_q[USC_CFG_ODD];
                  rx_st_q   <= USC_STOP;
               end
               default: begin
                  rx_ferr_q <= !RXD_IN;
                  rx_done_q <= 1'b1;
                  rx_st_q   <= USC_IDLE;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Handshake output
   // ---------------------------------------------------------------
   always_ff @(posedge REF_CLK_IN) begin
      if (!NRST_IN) begin
         RX_READY_REQUEST_N_OUT <= 1'b1;
      end else if (!hs_en) begin
         RX_READY_REQUEST_N_OUT <= 1'b1;
      end else if (async_config_word_q[USC_CFG_AUTO]) begin
         RX_READY_REQUEST_N_OUT <= rx_cnt_q > USC_RTS_LIMIT;
      end else begin
         RX_READY_REQUEST_N_OUT <=
            async_config_word_q[USC_CFG_RTS];
      end
   end

   assign PRDATA_OUT  = prdata_q;
   assign PREADY_OUT  = pready_q;
   assign PSLVERR_OUT = pslverr_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic [16:0] start_len_q;
   always_ff @(posedge REF_CLK_IN) begin
      if (!NRST_IN || tx_st_q != USC_START) begin
         start_len_q <= 17'h0_0000;
      end else begin
         start_len_q <= start_len_q + 17'h0_0001;
      end
   end

   mode_gate_a: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
      (tx_st_q == USC_IDLE && !enabled) |=> tx_st_q == USC_IDLE)
      else $error("transmitter started while disabled");
   idle_line_a: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
      tx_st_q == USC_IDLE |-> TXD_OUT)
      else $error("line not high while idle");
   start_low_a: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
      tx_st_q == USC_START |-> !TXD_OUT)
      else $error("start bit not low");
   permit_hold_a: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
      (tx_st_q == USC_IDLE && hs_en && TX_PERMIT_N_IN)
      |=> tx_st_q == USC_IDLE)
      else $error("character began without permit");
   ready_auto_a: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
      (hs_en && async_config_word_q[USC_CFG_AUTO]) |=>
      RX_READY_REQUEST_N_OUT == ($past(rx_cnt_q) > USC_RTS_LIMIT))
      else $error("auto ready level wrong");
   ready_soft_a: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
      (hs_en && !async_config_word_q[USC_CFG_AUTO]) |=>
      RX_READY_REQUEST_N_OUT == $past(async_config_word_q[USC_CFG_RTS]))
      else $error("soft ready level wrong");
   fifo_bound_a: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
      tx_cnt_q <= USC_FIFO_DEPTH && rx_cnt_q <= USC_FIFO_DEPTH)
      else $error("fifo count out of range");
   bit_time_a: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
      (tx_st_q == USC_START && tx_tmr_q == 17'h0_0000) |->
      start_len_q == period - 17'h0_0001)
      else $error("start bit length wrong");
endmodule

/* test/usc_line_model.sv */
// Far-side serial device: sends frames on rxd, decodes frames from txd
// Assumes line signals change and are sampled on the rising clock edge
module usc_line_model (
   // Clock
   input  wire logic        clk_in,
   // Line
   input  wire logic        txd_in,
   output logic             rxd_out,
   output logic             permit_n_out,
   // Frame format
   input  wire logic [15:0] bt_in,
   input  wire logic [3:0]  nb_in,
   input  wire logic        pe_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] got_q[$];
   int         t0_q[$];
   int         cyc = 0;
   logic       last = 1'b1;
   logic [9:0] w;
   int         i;
   // ------------------------------------------------------------
   // Line drivers
   // ------------------------------------------------------------
   initial begin
      rxd_out = 1'b1; // Idle high
      permit_n_out = 1'b1; // Sending inhibited
   end
   task automatic permit(input logic v);
      permit_n_out <= v;
   endtask
   task automatic send(input logic [7:0] d, input logic p, input int stops);
      int k;
      rxd_out <= 1'b0; // Start, data, parity, stops
      repeat (bt_in) @(posedge clk_in);
      for (k = 0; k < nb_in; k++) begin
         rxd_out <= d[k];
         repeat (bt_in) @(posedge clk_in);
      end
      if (pe_in) begin
         rxd_out <= p;
         repeat (bt_in) @(posedge clk_in);
      end
      rxd_out <= 1'b1;
      repeat (stops * bt_in) @(posedge clk_in);
   endtask
   // ------------------------------------------------------------
   // Frame decoder: [9] start and stop good, [8] parity, data
   // ------------------------------------------------------------
   always @(posedge clk_in) cyc <= cyc + 1;
   initial forever begin
      @(posedge clk_in);
      if (last === 1'b1 && txd_in === 1'b0) begin
         t0_q.push_back(cyc);
         w = 10'h000;
         repeat (bt_in / 2) @(posedge clk_in);
         w[9] = ~txd_in;
         for (i = 0; i < nb_in; i++) begin
            repeat (bt_in) @(posedge clk_in);
            w[i] = txd_in;
         end
         if (pe_in) begin
            repeat (bt_in) @(posedge clk_in);
            w[8] = txd_in;
         end
         repeat (bt_in) @(posedge clk_in);
         w[9] = w[9] & txd_in;
         got_q.push_back(w);
      end
      last = txd_in;
   end
endmodule

/* test/testbench.sv */
// Self-checking bench for the serial core over APB, DMA and the line
// Assumes usc_pkg, usc_core and usc_line_model are compiled first
module testbench;
   import usc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0;
   logic        pwr = 1'b0, txreq = 1'b0, rxreq = 1'b0, bad2 = 1'b0;
   logic [7:0]  paddr = 8'h00, txdat = 8'h00, rxdat, msk = 8'hFF, dd;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic        pready, pslverr, err, txack, rxack, txd, rxd, pmt_n;
   logic        rts_n, txd2, rts2_n, pe = 1'b0, od = 1'b0;
   logic [15:0] bt = 16'h0010;
   logic [3:0]  nb = 4'h8;
   logic [9:0]  w;
   int          errors = 0, total_checks = 0, f, s;
   logic [6:0]  cfg_t [4] = '{7'h00, 7'h14, 7'h3C, 7'h38};
   logic [15:0] per_t [4] = '{16'h0008, 16'h0008, 16'h0009, 16'h0008};
   logic        frac_t [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
   always #50 clk = ~clk;
   usc_core usc_core_i (.REF_CLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel),
      .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
      .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .TX_DMA_REQ_IN(txreq), .TX_DMA_DATA_IN(txdat),
      .TX_DMA_ACK_OUT(txack), .RX_DMA_REQ_IN(rxreq), .RX_DMA_ACK_OUT(rxack),
      .RX_DMA_DATA_OUT(rxdat), .TXD_OUT(txd), .RXD_IN(rxd),
      .TX_PERMIT_N_IN(pmt_n), .RX_READY_REQUEST_N_OUT(rts_n));
   usc_core #(.HAS_ASYNC(1'b0)) usc_core_i2 (.REF_CLK_IN(clk),
      .NRST_IN(nrst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
      .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(), .PREADY_OUT(),
      .PSLVERR_OUT(), .TX_DMA_REQ_IN(txreq), .TX_DMA_DATA_IN(txdat),
      .TX_DMA_ACK_OUT(), .RX_DMA_REQ_IN(rxreq), .RX_DMA_ACK_OUT(),
      .RX_DMA_DATA_OUT(), .TXD_OUT(txd2), .RXD_IN(rxd),
      .TX_PERMIT_N_IN(pmt_n), .RX_READY_REQUEST_N_OUT(rts2_n));
   usc_line_model line_i (.clk_in(clk), .txd_in(txd), .rxd_out(rxd),
      .permit_n_out(pmt_n), .bt_in(bt), .nb_in(nb), .pe_in(pe));
   always @(posedge clk) if (nrst && (txd2 !== 1'b1 || rts2_n !== 1'b1))
      bad2 <= 1'b1;
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] v, input logic [31:0] e);
      total_checks++;
      if (v !== e) begin
         errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, v, e);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic dma(input logic tx);
      if (tx) txreq <= 1'b1;
      else rxreq <= 1'b1;
      do begin
         @(posedge clk);
      end while ((tx ? txack : rxack) !== 1'b1);
      txreq <= 1'b0;
      rxreq <= 1'b0;
   endtask
   task automatic wait_got(input int n);
      int k;
      k = 0;
      while (line_i.got_q.size() < n && k < 6000) begin
         @(posedge clk);
         k++;
      end
      check(32'(line_i.got_q.size()), 32'(n));
   endtask
   function automatic logic pbit(input logic [7:0] d);
      return ^(d & msk) ^ od;
   endfunction
   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      summarize;
   end
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      check({30'h0, txd, rts_n}, 32'h0000_0003);
      apb(1'b0, USC_MODE_OFS, 32'h0);
      check(rd, {29'h0, USC_MODE_RST});
      apb(1'b0, USC_PER_OFS, 32'h0);
      check(rd, {16'h0, USC_PER_RST});
      apb(1'b0, USC_CFG_OFS, 32'h0);
      check(rd, {25'h0, USC_CFG_RST});
      apb(1'b0, 8'h18, 32'h0);
      check(32'(err), 32'h1);
      line_i.send(8'h55, 1'b0, 1);
      apb(1'b0, USC_STAT_OFS, 32'h0);
      check(32'(rd[1]), 32'h0);
      apb(1'b1, USC_MODE_OFS, {29'h0, USC_MODE_ASYNC});
      for (f = 0; f < 4; f++) begin
         apb(1'b1, USC_PER_OFS, {16'h0, per_t[f]});
         apb(1'b1, USC_FRAC_OFS, {31'h0, frac_t[f]});
         apb(1'b1, USC_CFG_OFS, {25'h0, cfg_t[f]});
         bt = 16'(2 * per_t[f] + frac_t[f]);
         nb = cfg_t[f][USC_CFG_8BIT] ? 4'h8 : 4'h7;
         pe = cfg_t[f][USC_CFG_PAR];
         od = cfg_t[f][USC_CFG_ODD];
         msk = cfg_t[f][USC_CFG_8BIT] ? 8'hFF : 8'h7F;
         line_i.got_q.delete();
         line_i.t0_q.delete();
         apb(1'b1, USC_DATA_OFS, 32'h96 ^ f);
         apb(1'b1, USC_DATA_OFS, 32'h3C ^ f);
         wait_got(2);
         for (int j = 0; j < 2; j++) begin
            w = line_i.got_q[j];
            dd = (j == 0 ? 8'h96 : 8'h3C) ^ f[7:0];
            check(32'(w[7:0]), 32'(dd & msk));
            check(32'(w[9:8]), {31'h1, pe & pbit(dd)});
         end
         s = line_i.t0_q[1] - line_i.t0_q[0]
             - bt * (2 + nb + pe + cfg_t[f][USC_CFG_2STP]);
         check(32'(s >= 0 && s < bt / 2), 32'h1);
         for (int j = 0; j < 2; j++) begin
            dd = (j == 0 ? 8'h69 : 8'hC5) ^ f[7:0];
            line_i.send(dd, pbit(dd), 1);
         end
         apb(1'b0, USC_DATA_OFS, 32'h0);
         check(32'(rd[7:0]), 32'((8'h69 ^ f[7:0]) & msk));
         apb(1'b0, USC_DATA_OFS, 32'h0);
         check(32'(rd[7:0]), 32'((8'hC5 ^ f[7:0]) & msk));
      end
      line_i.send(8'h0F, ~pbit(8'h0F), 1);
      apb(1'b0, USC_STAT_OFS, 32'h0);
      check(32'(rd[5]), 32'h1);
      apb(1'b0, USC_DATA_OFS, 32'h0);
      apb(1'b1, USC_PER_OFS, 32'h8);
      apb(1'b1, USC_FRAC_OFS, 32'h0);
      apb(1'b1, USC_CFG_OFS, 32'h6);
      {bt, nb, pe, od, msk} = {16'h0010, 4'h8, 1'b0, 1'b0, 8'hFF};
      repeat (2) @(posedge clk);
      check(32'(rts_n), 32'h0);
      apb(1'b1, USC_CFG_OFS, 32'h7);
      repeat (2) @(posedge clk);
      check(32'(rts_n), 32'h1);
      line_i.got_q.delete();
      apb(1'b1, USC_DATA_OFS, 32'h11);
      apb(1'b1, USC_DATA_OFS, 32'h22);
      repeat (400) @(posedge clk);
      check(32'(line_i.got_q.size()), 32'h0);
      line_i.permit(1'b0);
      repeat (50) @(posedge clk);
      line_i.permit(1'b1);
      repeat (400) @(posedge clk);
      wait_got(1);
      check(32'(line_i.got_q[0]), 32'h211);
      line_i.permit(1'b0);
      wait_got(2);
      check(32'(line_i.got_q[1]), 32'h222);
      apb(1'b1, USC_CFG_OFS, 32'h46);
      for (f = 0; f < 4; f++) begin
         line_i.send(8'hA0 + f[7:0], 1'b0, 1);
         repeat (3) @(posedge clk);
         check(32'(rts_n), 32'(f >= 2));
      end
      for (f = 0; f < 4; f++) begin
         apb(1'b0, USC_DATA_OFS, 32'h0);
         check(32'(rd[7:0]), 32'(8'hA0 + f[7:0]));
      end
      repeat (2) @(posedge clk);
      check(32'(rts_n), 32'h0);
      apb(1'b1, USC_CFG_OFS, 32'h4);
      line_i.got_q.delete();
      txdat <= 8'h5A;
      dma(1'b1);
      wait_got(1);
      check(32'(line_i.got_q[0]), 32'h25A);
      line_i.send(8'hE7, 1'b0, 1);
      dma(1'b0);
      check(32'(rxdat), 32'hE7);
      check(32'(bad2), 32'h0);
      summarize;
   end
endmodule
